// ### rtl/tcc8_timer.sv
// Eight-bit timer/counter: counter unit, compare unit, APB register slave.
// Assumes one clock pclk; the crystal input is sampled as a plain pin.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module tcc8_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Crystal oscillator pin
    input wire logic crystal_osc_pin_a,
    // Interrupt service acknowledges from the CPU
    input wire logic overflow_irq_ack,
    input wire logic compare_irq_ack,
    // Outputs
    output logic compare_output,
    output logic overflow_irq,
    output logic compare_irq,
    output logic bottom
);
    import tcc8_pkg::*;

    typedef struct packed {
        logic [2:0] clock_select_field;
        tcc8_wgm_type waveform_mode_field;
        tcc8_com_type compare_output_mode;
        logic async_clock_select;
        logic [7:0] presc_limit;
        logic [7:0] presc_cnt;
        logic [7:0] timer_count;
        logic [7:0] compare_value;
        logic [7:0] compare_buffer;
        logic direction_down;
        logic match_pending;
        logic block_next;
        logic overflow_flag;
        logic compare_match_flag;
        logic overflow_irq_enable;
        logic compare_irq_enable;
        logic compare_output;
        logic [2:0] osc_sync;
        logic osc_level;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic bottom;
        logic overflow_irq;
        logic compare_irq;
    } tcc8_state_type;

    tcc8_state_type s_q;
    tcc8_state_type s_d;

    logic acc;
    logic wr;
    logic tick;
    logic is_pwm;
    logic [7:0] top_value;
    logic match;
    logic at_top;
    logic at_bottom;
    logic do_clear;
    logic do_match;
    logic force_cmp;
    logic osc_rise;
    logic cnt_wr;
    logic [7:0] next_count;
    tcc8_com_type com_live;

    always_comb begin
        s_d = s_q;
        acc = psel && penable && !s_q.pready;
        wr = acc && pwrite;
        // Crystal level accepted only once second and third stage agree; a one-cycle glitch is ignored
        osc_rise = 1'b0;
        s_d.osc_sync = {s_q.osc_sync[1:0], crystal_osc_pin_a};
        if (s_q.osc_sync[1] == s_q.osc_sync[2]) begin
            s_d.osc_level = s_q.osc_sync[2];
            osc_rise = s_q.osc_sync[2] && !s_q.osc_level;
        end
        // Timer clock enable: prescaled io clock or crystal edges
        tick = 1'b0;
        if (s_q.clock_select_field == TCC8_CS_STOP) begin
            tick = 1'b0;
            s_d.presc_cnt = TCC8_RST_PRESC;
        end else if (s_q.async_clock_select) begin
            tick = osc_rise;
        end else if (s_q.clock_select_field == TCC8_CS_DIRECT) begin
            tick = 1'b1;
        end else if (s_q.presc_cnt >= s_q.presc_limit) begin
            tick = 1'b1;
            s_d.presc_cnt = TCC8_RST_PRESC;
        end else begin
            s_d.presc_cnt = s_q.presc_cnt + TCC8_ONE;
        end
        // Mode decode
        is_pwm = s_q.waveform_mode_field == TCC8_WGM_PWM_PC || s_q.waveform_mode_field == TCC8_WGM_PWM_FAST;
        top_value = (s_q.waveform_mode_field == TCC8_WGM_CTC) ? s_q.compare_value : TCC8_MAX;
        at_top = s_q.timer_count == top_value;
        at_bottom = s_q.timer_count == TCC8_BOTTOM;
        match = s_q.timer_count == s_q.compare_value;
        cnt_wr = wr && paddr == TCC8_OFF_COUNT;
        force_cmp = wr && paddr == TCC8_OFF_CTRL && pwdata[TCC8_FOC_BIT] && !is_pwm;
        // Output mode written with the strobe applies at once
        com_live = (wr && paddr == TCC8_OFF_CTRL) ? tcc8_com_type'(pwdata[TCC8_COM_LSB +: 2])
            : s_q.compare_output_mode;
        // A match on this timer clock is lost if the counter was just written
        do_match = tick && match && !s_q.block_next;
        do_clear = s_q.waveform_mode_field == TCC8_WGM_CTC && do_match;
        // Overflow clears come first so a same-cycle set below wins
        if ((wr && paddr == TCC8_OFF_FLAGS && pwdata[TCC8_OVF_BIT]) || overflow_irq_ack) begin
            s_d.overflow_flag = 1'b0;
        end
        // Counter unit
        next_count = s_q.timer_count;
        if (tick) begin
            case (s_q.waveform_mode_field)
                TCC8_WGM_NORMAL: begin
                    next_count = s_q.timer_count + TCC8_ONE;
                    if (s_q.timer_count == TCC8_MAX) begin
                        s_d.overflow_flag = 1'b1;
                    end
                end
                TCC8_WGM_CTC: begin
                    next_count = do_clear ? TCC8_BOTTOM : s_q.timer_count + TCC8_ONE;
                    if (s_q.timer_count == TCC8_MAX) begin
                        s_d.overflow_flag = 1'b1;
                    end
                end
                TCC8_WGM_PWM_FAST: begin
                    next_count = s_q.timer_count + TCC8_ONE;
                    if (at_top) begin
                        s_d.overflow_flag = 1'b1;
                        s_d.compare_value = s_q.compare_buffer;
                    end
                end
                TCC8_WGM_PWM_PC: begin
                    if (at_top) begin
                        s_d.direction_down = 1'b1;
                        s_d.compare_value = s_q.compare_buffer;
                    end else if (at_bottom) begin
                        s_d.direction_down = 1'b0;
                        s_d.overflow_flag = 1'b1;
                    end
                    if (at_top || (!s_q.direction_down && !at_bottom)) begin
                        next_count = at_top ? s_q.timer_count - TCC8_ONE : s_q.timer_count + TCC8_ONE;
                    end else begin
                        next_count = at_bottom ? s_q.timer_count + TCC8_ONE : s_q.timer_count - TCC8_ONE;
                    end
                end
                default: begin
                    next_count = s_q.timer_count;
                end
            endcase
            s_d.block_next = 1'b0;
        end
        s_d.timer_count = next_count;
        // Flag set one timer clock after the match
        if (tick) begin
            s_d.match_pending = do_match;
        end
        if (tick && s_q.match_pending) begin
            s_d.compare_match_flag = 1'b1;
        end
        // Compare output; kept across mode changes, mode bits read live
        if (do_match || force_cmp) begin
            case (com_live)
                TCC8_COM_TOGGLE: s_d.compare_output = !s_q.compare_output;
                TCC8_COM_CLEAR: s_d.compare_output = is_pwm && s_q.direction_down;
                TCC8_COM_SET: s_d.compare_output = !(is_pwm && s_q.direction_down);
                default: s_d.compare_output = s_q.compare_output;
            endcase
        end
        // Register writes
        if (cnt_wr) begin
            s_d.timer_count = pwdata[7:0];
            s_d.block_next = 1'b1;
            s_d.match_pending = 1'b0;
        end
        if (wr) begin
            case (paddr)
                TCC8_OFF_CTRL: begin
                    s_d.clock_select_field = pwdata[TCC8_CS_LSB +: 3];
                    s_d.waveform_mode_field = tcc8_wgm_type'(pwdata[TCC8_WGM_LSB +: 2]);
                    s_d.compare_output_mode = tcc8_com_type'(pwdata[TCC8_COM_LSB +: 2]);
                end
                TCC8_OFF_CMP: begin
                    if (is_pwm) begin
                        s_d.compare_buffer = pwdata[7:0];
                    end else begin
                        s_d.compare_value = pwdata[7:0];
                        s_d.compare_buffer = pwdata[7:0];
                    end
                end
                TCC8_OFF_IRQEN: begin
                    s_d.overflow_irq_enable = pwdata[TCC8_OVF_BIT];
                    s_d.compare_irq_enable = pwdata[TCC8_CMF_BIT];
                end
                TCC8_OFF_ASYNC: s_d.async_clock_select = pwdata[TCC8_ASYNC_BIT];
                TCC8_OFF_PRESC: s_d.presc_limit = pwdata[7:0];
                default: s_d.presc_limit = s_q.presc_limit;
            endcase
        end
        // Flag clears by write-one or service; a same-cycle set wins
        if ((wr && paddr == TCC8_OFF_FLAGS && pwdata[TCC8_CMF_BIT]) || compare_irq_ack) begin
            if (!(tick && s_q.match_pending)) begin
                s_d.compare_match_flag = 1'b0;
            end
        end
        // Read path
        s_d.pready = acc;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (acc) begin
            case (paddr)
                TCC8_OFF_CTRL: s_d.prdata = {24'h000000, 1'b0, s_q.compare_output_mode, s_q.waveform_mode_field,
                    s_q.clock_select_field};
                TCC8_OFF_COUNT: s_d.prdata = {24'h000000, s_q.timer_count};
                TCC8_OFF_CMP: s_d.prdata = {24'h000000, is_pwm ? s_q.compare_buffer : s_q.compare_value};
                TCC8_OFF_FLAGS: s_d.prdata = {30'h00000000, s_q.compare_match_flag, s_q.overflow_flag};
                TCC8_OFF_IRQEN: s_d.prdata = {30'h00000000, s_q.compare_irq_enable, s_q.overflow_irq_enable};
                TCC8_OFF_ASYNC: s_d.prdata = {31'h00000000, s_q.async_clock_select};
                TCC8_OFF_PRESC: s_d.prdata = {24'h000000, s_q.presc_limit};
                default: s_d.pslverr = 1'b1;
            endcase
        end
        s_d.bottom = s_d.timer_count == TCC8_BOTTOM;
        s_d.compare_irq = s_d.compare_match_flag && s_d.compare_irq_enable;
        s_d.overflow_irq = s_d.overflow_flag && s_d.overflow_irq_enable;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign compare_output = s_q.compare_output;
    assign overflow_irq = s_q.overflow_irq;
    assign compare_irq = s_q.compare_irq;
    assign bottom = s_q.bottom;
endmodule : tcc8_timer

// ### rtl/tcc8_pkg.sv
// Package for the eight-bit timer/counter with one compare unit.
// Assumes an APB slave with 32-bit data; registers one aligned word each.
package tcc8_pkg;
    // Register byte offsets
    localparam logic [7:0] TCC8_OFF_CTRL = 8'h00;
    localparam logic [7:0] TCC8_OFF_COUNT = 8'h04;
    localparam logic [7:0] TCC8_OFF_CMP = 8'h08;
    localparam logic [7:0] TCC8_OFF_FLAGS = 8'h0C;
    localparam logic [7:0] TCC8_OFF_IRQEN = 8'h10;
    localparam logic [7:0] TCC8_OFF_ASYNC = 8'h14;
    localparam logic [7:0] TCC8_OFF_PRESC = 8'h18;
    // Control register field positions
    localparam int TCC8_CS_LSB = 0;
    localparam int TCC8_WGM_LSB = 3;
    localparam int TCC8_COM_LSB = 5;
    localparam int TCC8_FOC_BIT = 7;
    // Flag and enable bit positions
    localparam int TCC8_OVF_BIT = 0;
    localparam int TCC8_CMF_BIT = 1;
    localparam int TCC8_ASYNC_BIT = 0;
    // Counter limits
    localparam logic [7:0] TCC8_BOTTOM = 8'h00;
    localparam logic [7:0] TCC8_MAX = 8'hFF;
    localparam logic [7:0] TCC8_ONE = 8'h01;
    // Reset values
    localparam logic [7:0] TCC8_RST_BYTE = 8'h00;
    localparam logic [7:0] TCC8_RST_PRESC = 8'h00;
    // Waveform modes
    typedef enum logic [1:0] {
        TCC8_WGM_NORMAL = 2'h0,
        TCC8_WGM_PWM_PC = 2'h1,
        TCC8_WGM_CTC = 2'h2,
        TCC8_WGM_PWM_FAST = 2'h3
    } tcc8_wgm_type;
    // Compare output actions
    typedef enum logic [1:0] {
        TCC8_COM_NONE = 2'h0,
        TCC8_COM_TOGGLE = 2'h1,
        TCC8_COM_CLEAR = 2'h2,
        TCC8_COM_SET = 2'h3
    } tcc8_com_type;
    localparam logic [2:0] TCC8_CS_STOP = 3'h0;
    localparam logic [2:0] TCC8_CS_DIRECT = 3'h1;
endpackage : tcc8_pkg

// ### test/tcc8_timer_props.sv
// Checker for the timer block: bus handshake, address map and interrupt relations.
// Sees only top ports; shadows clock select and enables from observed APB writes.
`timescale 1ns/10ps
module tcc8_timer_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // Pins
    input wire logic crystal_osc_pin_a,
    input wire logic overflow_irq_ack,
    input wire logic compare_irq_ack,
    input wire logic compare_output,
    input wire logic overflow_irq,
    input wire logic compare_irq,
    input wire logic bottom
);
    import tcc8_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic take;
    logic [2:0] cs_q;
    logic [1:0] en_q;
    assign take = psel && penable && pwrite && !pready;
    // Shadows follow the write edge, so irq checks allow one cycle of lag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_q <= 3'h0;
            en_q <= 2'h0;
        end else begin
            if (take && paddr == TCC8_OFF_CTRL) cs_q <= pwdata[2:0];
            if (take && paddr == TCC8_OFF_IRQEN) en_q <= pwdata[1:0];
        end
    end
    property p_answer; psel && penable && !pready |=> pready; endproperty
    a_answer: assert property (p_answer) else $error("access not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_map; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > TCC8_OFF_PRESC); endproperty
    a_map: assert property (p_map) else $error("error response wrong");
    property p_upper; pready |-> prdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_stop; (cs_q == 3'h0 && !take)[*3] |=> $stable(bottom); endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");
    property p_cmp_ack; compare_irq && compare_irq_ack && cs_q == 3'h0 |-> ##[1:2] !compare_irq; endproperty
    a_cmp_ack: assert property (p_cmp_ack) else $error("service left compare request");
    property p_ovf_ack; overflow_irq && overflow_irq_ack && cs_q == 3'h0 |-> ##[1:2] !overflow_irq; endproperty
    a_ovf_ack: assert property (p_ovf_ack) else $error("service left overflow request");
    property p_cmp_en; $rose(compare_irq) |-> en_q[1] || $past(en_q[1]); endproperty
    a_cmp_en: assert property (p_cmp_en) else $error("compare request while disabled");
    property p_ovf_en; $rose(overflow_irq) |-> en_q[0] || $past(en_q[0]); endproperty
    a_ovf_en: assert property (p_ovf_en) else $error("overflow request while disabled");
    c_cmp: cover property ($rose(compare_irq));
    c_ovf: cover property ($rose(overflow_irq));
    c_err: cover property (pready && pslverr);
endmodule : tcc8_timer_props
bind tcc8_timer tcc8_timer_props i_tcc8_timer_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .crystal_osc_pin_a(crystal_osc_pin_a), .overflow_irq_ack(overflow_irq_ack),
    .compare_irq_ack(compare_irq_ack), .compare_output(compare_output), .overflow_irq(overflow_irq),
    .compare_irq(compare_irq), .bottom(bottom));

// ### test/tb.sv
// Self-checking bench: register rows in a loop, then hand-written timing cases.
// Assumes one pclk domain; waits are bounded, counter runs with clock select 1.
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("Error %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb;
    import tcc8_pkg::*;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic e;} tcc8_row_type;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, xtal = 1'b0, ovf_ack = 1'b0, cmp_ack = 1'b0;
    logic compare_output, overflow_irq, compare_irq, bottom;
    int bad_count = 0, n_tests = 0, k;
    tcc8_row_type rows [16];
    always #4 pclk = ~pclk;
    tcc8_timer i_tcc8_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_osc_pin_a(xtal), .overflow_irq_ack(ovf_ack), .compare_irq_ack(cmp_ack),
        .compare_output(compare_output), .overflow_irq(overflow_irq), .compare_irq(compare_irq), .bottom(bottom));
    task automatic conclude();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // Request held until pready is seen high; one idle cycle after each transfer
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("Error %0t: no bus answer", $time);
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        apb(a, 1'b1, d, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        logic e;
        apb(a, 1'b0, 32'h0, e);
        `CHK(r, x)
    endtask : rd
    task automatic wait_irq(input logic cmp);
        k = 0;
        while ((cmp ? compare_irq : overflow_irq) !== 1'b1 && k < 400) begin
            @(posedge pclk);
            k++;
        end
        if ((cmp ? compare_irq : overflow_irq) !== 1'b1) begin
            bad_count++;
            $display("Error %0t: interrupt missing", $time);
            conclude();
        end
    endtask : wait_irq
    initial begin
        logic e;
        rows = '{'{8'h10, 1'b1, 32'h3, 1'b0}, '{8'h10, 1'b0, 32'h3, 1'b0}, '{8'h14, 1'b1, 32'h1, 1'b0},
            '{8'h14, 1'b0, 32'h1, 1'b0}, '{8'h14, 1'b1, 32'h0, 1'b0}, '{8'h18, 1'b1, 32'hA5, 1'b0},
            '{8'h18, 1'b0, 32'hA5, 1'b0}, '{8'h04, 1'b1, 32'h37, 1'b0}, '{8'h04, 1'b0, 32'h37, 1'b0},
            '{8'h08, 1'b1, 32'h5A, 1'b0}, '{8'h08, 1'b0, 32'h5A, 1'b0}, '{8'h00, 1'b1, 32'h60, 1'b0},
            '{8'h00, 1'b0, 32'h60, 1'b0}, '{8'h1C, 1'b1, 32'h1, 1'b1}, '{8'h1C, 1'b0, 32'h0, 1'b1},
            '{8'h10, 1'b1, 32'h2, 1'b0}};
        tick(3);
        presetn <= 1'b1;
        `CHK({compare_output, overflow_irq, compare_irq, bottom}, 4'h0)
        tick(3);
        `CHK(bottom, 1'b1)
        for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0);
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].w, rows[i].d, e);
            if (!rows[i].w) `CHK(r, rows[i].d)
            `CHK(e, rows[i].e)
        end
        `CHK(bottom, 1'b0)
        wr(8'h04, 32'hFD);
        wr(8'h10, 32'h3);
        wr(8'h00, 32'h1);
        wait_irq(1'b0);
        wr(8'h00, 32'h0);
        rd(8'h0C, 32'h1);
        ovf_ack <= 1'b1;
        tick(1);
        ovf_ack <= 1'b0;
        tick(3);
        `CHK(overflow_irq, 1'b0)
        wr(8'h08, 32'h20);
        wr(8'h04, 32'h1E);
        wr(8'h00, 32'h1);
        wait_irq(1'b1);
        wr(8'h00, 32'h0);
        rd(8'h0C, 32'h2);
        cmp_ack <= 1'b1;
        tick(1);
        cmp_ack <= 1'b0;
        tick(3);
        `CHK(compare_irq, 1'b0)
        wr(8'h04, 32'h1F);
        wr(8'h00, 32'h1);
        wait_irq(1'b1);
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h2);
        rd(8'h0C, 32'h0);
        $display("test done: flags");
        // Counter written equal to compare: the first tick must not match
        wr(8'h04, 32'h20);
        wr(8'h00, 32'h1);
        tick(20);
        wr(8'h00, 32'h0);
        rd(8'h0C, 32'h0);
        wr(8'h08, 32'h5);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h11);
        for (int i = 0; i < 6; i++) begin
            apb(8'h04, 1'b0, 32'h0, e);
            `CHK(r <= 32'h5, 1'b1)
        end
        wr(8'h00, 32'h0);
        wr(8'h0C, 32'h3);
        $display("test done: block and clear on compare");
        for (int c = 3; c >= 0; c--) begin
            wr(8'h00, 32'h80 | (c << 5));
            `CHK(compare_output, c != 2)
        end
        rd(8'h0C, 32'h0);
        wr(8'h00, 32'h08);
        `CHK(compare_output, 1'b1)
        wr(8'h00, 32'h18);
        wr(8'h04, 32'h20);
        wr(8'h08, 32'h22);
        rd(8'h08, 32'h22);
        wr(8'h00, 32'h19);
        wr(8'h00, 32'h18);
        rd(8'h0C, 32'h0);
        wr(8'h00, 32'h19);
        wait_irq(1'b1);
        wr(8'h00, 32'h18);
        $display("test done: force and buffering");
        wr(8'h00, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h14, 32'h1);
        wr(8'h00, 32'h1);
        tick(10);
        rd(8'h04, 32'h0);
        repeat (5) begin
            xtal <= 1'b1;
            tick(4);
            xtal <= 1'b0;
            tick(4);
        end
        tick(4);
        rd(8'h04, 32'h5);
        wr(8'h14, 32'h0);
        presetn <= 1'b0;
        tick(3);
        `CHK({compare_output, overflow_irq, compare_irq}, 3'h0)
        presetn <= 1'b1;
        rd(8'h00, 32'h0);
        $display("test done: crystal and reset");
        conclude();
    end
endmodule : tb
